// ### rtl/plb_bw_decode.sv
`timescale 1ns/1ps
module plb_bw_decode
    import plb_pkg::*;
#(
    parameter bit FIRST_LOOP = 1'b0
) (
    plb_bw_if.dec port
);

    always_comb begin
        port.bw = PLB_BW_NONE;
        port.valid = 1'b0;
        if (FIRST_LOOP) begin
            case (port.code)
                PLB_FIRST_CODE_18: begin
                    port.bw = PLB_BW_18;
                    port.valid = 1'b1;
                end
                PLB_FIRST_CODE_35: begin
                    port.bw = PLB_BW_35;
                    port.valid = 1'b1;
                end
                PLB_FIRST_CODE_70: begin
                    port.bw = PLB_BW_70;
                    port.valid = 1'b1;
                end
                default: begin
                    port.bw = PLB_BW_NONE;
                    port.valid = 1'b0;
                end
            endcase
        end else begin
            case (port.code)
                PLB_SEC_CODE_18: begin
                    port.bw = PLB_BW_18;
                    port.valid = 1'b1;
                end
                PLB_SEC_CODE_35: begin
                    port.bw = PLB_BW_35;
                    port.valid = 1'b1;
                end
                PLB_SEC_CODE_70: begin
                    port.bw = PLB_BW_70;
                    port.valid = 1'b1;
                end
                default: begin
                    port.bw = PLB_BW_NONE;
                    port.valid = 1'b0;
                end
            endcase
        end
    end

endmodule // plb_bw_decode

// ### rtl/plb_bw_if.sv
`timescale 1ns/1ps
interface plb_bw_if;
    import plb_pkg::*;
    logic [1:0] code;
    plb_bw_e bw;
    logic valid;
    modport src (output code, input bw, input valid);
    modport dec (input code, output bw, output valid);
endinterface

// ### rtl/plb_cfg.sv
`timescale 1ns/1ps
// How it works
// - Second loop codes 00, 01, 10 give 18, 35, 70 Hz; 11 is invalid.
// - First loop locked codes 11, 00, 01 give 18, 35, 70 Hz; 10 is unused.
// - In auto mode while acquiring, the acquisition field applies alike.
// - The auto bit picks locked always, or acquisition until phase lock.
module plb_cfg
    import plb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic auto_acq_bw_en,
    input wire logic phase_locked,
    output plb_bw_e second_loop_bw_sel,
    output plb_bw_e first_loop_bw_sel,
    output logic first_loop_acquiring,
    output logic bw_code_bad
);

    logic [1:0] sec_ff;
    logic [1:0] nxt_sec;
    logic [1:0] lck_ff;
    logic [1:0] nxt_lck;
    logic [3:0] acq_ff;
    logic [3:0] nxt_acq;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    plb_state_e state_ff;
    plb_state_e nxt_state;
    plb_bw_e sec_bw_ff;
    plb_bw_e nxt_sec_bw;
    plb_bw_e first_bw_ff;
    plb_bw_e nxt_first_bw;
    logic acquiring_ff;
    logic nxt_acquiring;
    logic bad_ff;
    logic nxt_bad;
    logic sel_valid;
    plb_bw_e sel_bw;

    plb_bw_if sec_if ();
    plb_bw_if lck_if ();
    plb_bw_if acq_if ();

    assign sec_if.code = sec_ff;
    assign lck_if.code = lck_ff;
    assign acq_if.code = acq_ff[1:0];

    plb_bw_decode #(.FIRST_LOOP(1'b0)) u_sec_dec (.port(sec_if.dec));
    plb_bw_decode #(.FIRST_LOOP(1'b1)) u_lck_dec (.port(lck_if.dec));
    plb_bw_decode #(.FIRST_LOOP(1'b1)) u_acq_dec (.port(acq_if.dec));

    // register writes and reads
    always_comb begin
        nxt_sec = sec_ff;
        nxt_lck = lck_ff;
        nxt_acq = acq_ff;
        nxt_rd_valid = reg_rd_en;
        nxt_rd_data = rd_data_ff;
        if (reg_wr_en) begin
            case (reg_addr)
                PLB_ADDR_SECOND_BW: nxt_sec = reg_wr_data[1:0];
                PLB_ADDR_FIRST_LOCKED_BW: nxt_lck = reg_wr_data[1:0];
                PLB_ADDR_FIRST_ACQUIRE_BW: nxt_acq = reg_wr_data[3:0];
                default: nxt_sec = sec_ff;
            endcase
        end
        if (reg_rd_en) begin
            // upper bits are not stored; they read as the reset pattern
            case (reg_addr)
                PLB_ADDR_SECOND_BW:
                    nxt_rd_data = (PLB_RST_SECOND_BW & ~PLB_MASK_BW_SEL)
                        | {6'h00, sec_ff};
                PLB_ADDR_FIRST_LOCKED_BW:
                    nxt_rd_data = (PLB_RST_FIRST_LOCKED_BW & ~PLB_MASK_BW_SEL)
                        | {6'h00, lck_ff};
                PLB_ADDR_FIRST_ACQUIRE_BW:
                    nxt_rd_data =
                        (PLB_RST_FIRST_ACQUIRE_BW & ~PLB_MASK_ACQ_FIELD)
                        | {4'h0, acq_ff};
                default: nxt_rd_data = PLB_RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sec_ff <= PLB_RST_SECOND_BW[1:0];
            lck_ff <= PLB_RST_FIRST_LOCKED_BW[1:0];
            acq_ff <= PLB_RST_FIRST_ACQUIRE_BW[3:0];
            rd_data_ff <= PLB_RD_UNMAPPED;
            rd_valid_ff <= 1'b0;
        end else begin
            sec_ff <= nxt_sec;
            lck_ff <= nxt_lck;
            acq_ff <= nxt_acq;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // acquisition tracking; loss of lock goes back to acquisition
    always_comb begin
        nxt_state = PLB_ST_LOCKED;
        case (state_ff)
            PLB_ST_ACQUIRE: begin
                if (!auto_acq_bw_en || phase_locked) begin
                    nxt_state = PLB_ST_LOCKED;
                end else begin
                    nxt_state = PLB_ST_ACQUIRE;
                end
            end
            PLB_ST_LOCKED: begin
                if (auto_acq_bw_en && !phase_locked) begin
                    nxt_state = PLB_ST_ACQUIRE;
                end else begin
                    nxt_state = PLB_ST_LOCKED;
                end
            end
            default: nxt_state = PLB_ST_LOCKED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= PLB_ST_LOCKED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // applied bandwidths; an invalid code holds the last good setting so
    // that a bad write never disturbs a running loop
    always_comb begin
        sel_bw = lck_if.bw;
        sel_valid = lck_if.valid;
        if (state_ff == PLB_ST_ACQUIRE) begin
            sel_bw = acq_if.bw;
            sel_valid = acq_if.valid;
        end
        nxt_sec_bw = sec_bw_ff;
        if (sec_if.valid) begin
            nxt_sec_bw = sec_if.bw;
        end
        nxt_first_bw = first_bw_ff;
        if (sel_valid) begin
            nxt_first_bw = sel_bw;
        end
        nxt_acquiring = (state_ff == PLB_ST_ACQUIRE);
        nxt_bad = !sec_if.valid || !sel_valid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sec_bw_ff <= PLB_BW_18;
            first_bw_ff <= PLB_BW_35;
            acquiring_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else begin
            sec_bw_ff <= nxt_sec_bw;
            first_bw_ff <= nxt_first_bw;
            acquiring_ff <= nxt_acquiring;
            bad_ff <= nxt_bad;
        end
    end

    assign reg_rd_data = rd_data_ff;
    assign reg_rd_valid = rd_valid_ff;
    assign second_loop_bw_sel = sec_bw_ff;
    assign first_loop_bw_sel = first_bw_ff;
    assign first_loop_acquiring = acquiring_ff;
    assign bw_code_bad = bad_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sec_map_a: assert property (
        (sec_ff == PLB_SEC_CODE_70) |=> (second_loop_bw_sel == PLB_BW_70))
        else $error("second loop code 10 not applied as 70 Hz");

    sec_bad_hold_a: assert property (
        (sec_ff == PLB_SEC_CODE_BAD) |=> $stable(second_loop_bw_sel))
        else $error("second loop bandwidth moved on code 11");

    lck_map_a: assert property (
        (state_ff == PLB_ST_LOCKED && lck_ff == PLB_FIRST_CODE_18)
        |=> (first_loop_bw_sel == PLB_BW_18))
        else $error("locked code 11 not applied as 18 Hz");

    acq_map_a: assert property (
        (state_ff == PLB_ST_ACQUIRE && acq_ff[1:0] == PLB_FIRST_CODE_70)
        |=> (first_loop_bw_sel == PLB_BW_70))
        else $error("acquisition code 01 not applied as 70 Hz");

    auto_off_a: assert property (
        (!auto_acq_bw_en) [*2] |-> (state_ff == PLB_ST_LOCKED)
        ##1 !first_loop_acquiring)
        else $error("acquisition used while auto mode is off");

    lock_switch_a: assert property (
        (auto_acq_bw_en && !phase_locked) ##1 (auto_acq_bw_en && phase_locked)
        |-> (state_ff == PLB_ST_ACQUIRE) ##1 (state_ff == PLB_ST_LOCKED))
        else $error("no switch to locked bandwidth on lock");

    wr_rd_locked_a: assert property (
        (reg_wr_en && reg_addr == PLB_ADDR_FIRST_LOCKED_BW)
        ##1 (reg_rd_en && reg_addr == PLB_ADDR_FIRST_LOCKED_BW && !reg_wr_en)
        |=> reg_rd_valid && reg_rd_data ==
            ((PLB_RST_FIRST_LOCKED_BW & ~PLB_MASK_BW_SEL)
            | {6'h00, $past(reg_wr_data[1:0], 2)}))
        else $error("locked register readback wrong");

    unmapped_rd_a: assert property (
        (reg_rd_en && reg_addr != PLB_ADDR_SECOND_BW
        && reg_addr != PLB_ADDR_FIRST_LOCKED_BW
        && reg_addr != PLB_ADDR_FIRST_ACQUIRE_BW)
        |=> (reg_rd_valid && reg_rd_data == PLB_RD_UNMAPPED))
        else $error("unmapped read not zero");

    acq_to_lock_c: cover property (
        first_loop_acquiring ##[1:20] !first_loop_acquiring);
    sec_70_c: cover property (second_loop_bw_sel == PLB_BW_70);
    bad_code_c: cover property (bw_code_bad);
    acq_read_c: cover property (
        reg_rd_en && reg_addr == PLB_ADDR_FIRST_ACQUIRE_BW);

endmodule // plb_cfg

// ### rtl/plb_pkg.sv
package plb_pkg;

    localparam int PLB_ADDR_W = 7;
    localparam int PLB_DATA_W = 8;

    // register offsets on the serial interface
    localparam logic [6:0] PLB_ADDR_SECOND_BW = 7'h66;
    localparam logic [6:0] PLB_ADDR_FIRST_LOCKED_BW = 7'h67;
    localparam logic [6:0] PLB_ADDR_FIRST_ACQUIRE_BW = 7'h69;

    // reset values, whole byte as read back
    localparam logic [7:0] PLB_RST_SECOND_BW = 8'h00;
    localparam logic [7:0] PLB_RST_FIRST_LOCKED_BW = 8'h10;
    localparam logic [7:0] PLB_RST_FIRST_ACQUIRE_BW = 8'h11;

    // field widths; the acquisition field is four bits wide, code in [1:0]
    localparam int PLB_BW_SEL_W = 2;
    localparam int PLB_ACQ_FIELD_W = 4;
    localparam logic [7:0] PLB_MASK_BW_SEL = 8'h03;
    localparam logic [7:0] PLB_MASK_ACQ_FIELD = 8'h0f;

    // second loop codes
    localparam logic [1:0] PLB_SEC_CODE_18 = 2'h0;
    localparam logic [1:0] PLB_SEC_CODE_35 = 2'h1;
    localparam logic [1:0] PLB_SEC_CODE_70 = 2'h2;
    localparam logic [1:0] PLB_SEC_CODE_BAD = 2'h3;

    // first loop codes, shared by locked and acquisition fields
    localparam logic [1:0] PLB_FIRST_CODE_18 = 2'h3;
    localparam logic [1:0] PLB_FIRST_CODE_35 = 2'h0;
    localparam logic [1:0] PLB_FIRST_CODE_70 = 2'h1;
    localparam logic [1:0] PLB_FIRST_CODE_BAD = 2'h2;

    localparam logic [7:0] PLB_RD_UNMAPPED = 8'h00;

    typedef enum logic [1:0] {
        PLB_BW_18,
        PLB_BW_35,
        PLB_BW_70,
        PLB_BW_NONE
    } plb_bw_e;

    typedef enum logic {
        PLB_ST_ACQUIRE,
        PLB_ST_LOCKED
    } plb_state_e;

endpackage

// ### test/tb_pll_loop_bandwidth_config.sv
`timescale 1ns/1ps
module tb_pll_loop_bandwidth_config;
    import plb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] addr = 7'h00;
    logic wr_en = 1'b0;
    logic [7:0] wr_d = 8'h00;
    logic rd_en = 1'b0;
    logic [7:0] rd_d;
    logic rd_v;
    logic auto_en = 1'b0;
    logic locked = 1'b0;
    plb_bw_e sec_sel;
    plb_bw_e fst_sel;
    logic acq;
    logic bad;
    int fail_count = 0;
    int checks = 0;
    int k;
    logic [31:0] rnd = 32'h3628ef75;
    logic [6:0] amap [4] = '{7'h66, 7'h67, 7'h69, 7'h6a};
    // shadow of raw bytes written; index 3 is an unmapped address
    logic [7:0] sh [4] = '{8'h00, 8'h10, 8'h11, 8'h00};
    plb_bw_e sec_bw = PLB_BW_18;
    plb_bw_e lk_bw = PLB_BW_35;
    logic [1:0] c0;
    logic [1:0] c1;
    plb_bw_e aq_bw;
    logic exp_bad;

    initial begin
        forever #12.5 clk = ~clk;
    end

    plb_cfg dut_u (
        .clk(clk), .rst(rst), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wr_d), .reg_rd_en(rd_en), .reg_rd_data(rd_d),
        .reg_rd_valid(rd_v), .auto_acq_bw_en(auto_en),
        .phase_locked(locked), .second_loop_bw_sel(sec_sel),
        .first_loop_bw_sel(fst_sel), .first_loop_acquiring(acq),
        .bw_code_bad(bad)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // first loop codes are the second loop codes rotated by one
    function automatic plb_bw_e map2(input logic [1:0] c, input bit fst,
                                     input plb_bw_e old);
        logic [1:0] r;
        r = fst ? c + 2'h1 : c;
        return (r == 2'h3) ? old : plb_bw_e'(r);
    endfunction

    function automatic logic [7:0] exp_rb(input int i, input logic [7:0] d);
        case (i)
            0: return {6'h00, d[1:0]};
            1: return {6'h04, d[1:0]};
            2: return {4'h1, d[3:0]};
            default: return 8'h00;
        endcase
    endfunction

    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        addr = amap[i];
        wr_d = d;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
        if (i < 3) sh[i] = d;
    endtask

    // a write strobe left high by the caller is taken in the same cycle
    task automatic rd(input int i);
        int n;
        addr = amap[i];
        rd_en = 1'b1;
        step(1);
        rd_en = 1'b0;
        wr_en = 1'b0;
        for (n = 0; n < 3 && rd_v !== 1'b1; n++) step(1);
        if (rd_v !== 1'b1) begin
            fail_count++;
            $display("[ERR] reg_rd_valid expected 1 seen %b", rd_v);
            give_verdict();
        end else begin
            chk("reg_rd_data", exp_rb(i, sh[i]), rd_d);
            // idle edge so a following read never re-raises the strobe
            // in the time step that lowered it
            step(1);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("second_loop_bw_sel", 8'(PLB_BW_18), 8'(sec_sel));
        chk("first_loop_bw_sel", 8'(PLB_BW_35), 8'(fst_sel));
        for (int i = 0; i < 4; i++) rd(i);
        for (int i = 0; i < 5; i++) begin
            c0 = 2'(i + 1);
            c1 = 2'(i + 3);
            rnd = lfsr(rnd);
            wr(0, {rnd[7:2], c0});
            step(1);
            wr(1, {rnd[15:10], c1});
            step(3);
            sec_bw = map2(c0, 1'b0, sec_bw);
            lk_bw = map2(c1, 1'b1, lk_bw);
            chk("second_loop_bw_sel", 8'(sec_bw), 8'(sec_sel));
            chk("first_loop_bw_sel", 8'(lk_bw), 8'(fst_sel));
            exp_bad = (c0 == 2'h3 || c1 == 2'h2);
            chk("bw_code_bad", 8'(exp_bad), 8'(bad));
            rd(0);
            rd(1);
        end
        auto_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            c0 = 2'(i + 3);
            locked = 1'b0;
            rnd = lfsr(rnd);
            wr(2, {rnd[7:2], c0});
            step(4);
            aq_bw = map2(c0, 1'b1, lk_bw);
            chk("first_loop_bw_sel", 8'(aq_bw), 8'(fst_sel));
            chk("first_loop_acquiring", 8'h01, 8'(acq));
            rd(2);
            locked = 1'b1;
            step(4);
            chk("first_loop_bw_sel", 8'(lk_bw), 8'(fst_sel));
            chk("first_loop_acquiring", 8'h00, 8'(acq));
        end
        auto_en = 1'b0;
        locked = 1'b0;
        step(4);
        chk("first_loop_bw_sel", 8'(lk_bw), 8'(fst_sel));
        chk("first_loop_acquiring", 8'h00, 8'(acq));
        wr_d = 8'h02;
        wr_en = 1'b1;
        rd(0);
        sh[0] = 8'h02;
        rd(0);
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            k = int'(rnd[1:0]);
            wr(k, rnd[15:8]);
            rd(k);
            rd(int'(rnd[17:16]));
        end
        give_verdict();
    end
endmodule // tb_pll_loop_bandwidth_config
